// file: design/flash_frame_defs.svh
// Constants for the serial flash command framing block.
// Assumes SPI mode 0: input sampled on rising serial clock, output changed on falling.
`ifndef FLASH_FRAME_DEFS_SVH
`define FLASH_FRAME_DEFS_SVH
`define OP_SEQ_PROG_A    8'had
`define OP_SEQ_PROG_B    8'haf
`define OP_BUF_TO_ARRAY  8'h88
`define OP_VOL_WREN      8'h50
`define OP_RD_STAT1      8'h05
`define OP_RD_STAT2      8'h35
`define OP_RD_STAT3      8'h15
`define OP_RD_STAT_SEL   8'h65
`define OP_WR_STAT1      8'h01
`define OP_WR_STAT2      8'h31
`define OP_WR_STAT3      8'h11
`define ADDR_BYTES       2'h3
`define STAT_RESET       8'h00
`endif

// file: design/flash_frame_pkg.sv
// Types for the serial flash command framing block.
// Assumes the constants header is included by the user.
package flash_frame_pkg;
    typedef enum {
        PH_OPCODE,
        PH_ADDR,
        PH_SEL,
        PH_DUMMY,
        PH_DATA_IN,
        PH_DATA_OUT,
        PH_DONE,
        PH_IGNORE
    } phase_t;
endpackage : flash_frame_pkg

// file: design/flash_frame.sv
// Command framing decoder of a serial flash, single-lane subset.
// Assumes serial pins come from another domain and are synchronised here.
`timescale 1ns/10ps
`include "flash_frame_defs.svh"

module flash_frame #(
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    // Serial pins
    input  wire logic              cs_n_i,
    input  wire logic              sclk_i,
    input  wire logic              mosi_i,
    output logic                   miso_o,
    output logic                   miso_oe_o,
    // Operation strobes toward the array
    output logic                   seq_wr_o,
    output logic [ADDR_W-1:0]      seq_addr_o,
    output logic [7:0]             seq_data_o,
    output logic                   buf_prog_o,
    output logic [ADDR_W-1:0]      buf_addr_o,
    output logic                   vol_wren_o,
    output logic                   stat_wr_o,
    output logic [1:0]             stat_idx_o,
    output logic [7:0]             stat_data_o,
    // Status values to return
    input  wire logic [7:0]        stat1_i,
    input  wire logic [7:0]        stat2_i,
    input  wire logic [7:0]        stat3_i,
    input  wire logic [7:0]        stat4_i,
    input  wire logic [7:0]        stat5_i,
    input  wire logic [7:0]        stat6_i
);
    // Three-stage synchronisers; only stages two and three are compared
    logic [2:0] cs_s_reg, ck_s_reg, di_s_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s_reg <= 3'h7;
            ck_s_reg <= 3'h0;
            di_s_reg <= 3'h0;
        end else begin
            cs_s_reg <= {cs_s_reg[1:0], cs_n_i};
            ck_s_reg <= {ck_s_reg[1:0], sclk_i};
            di_s_reg <= {di_s_reg[1:0], mosi_i};
        end
    end
    logic cs_lvl_reg, ck_lvl_reg;
    logic cs_lvl_next, ck_lvl_next;
    always_comb begin
        cs_lvl_next = (cs_s_reg[1] == cs_s_reg[2]) ? cs_s_reg[2] : cs_lvl_reg;
        ck_lvl_next = (ck_s_reg[1] == ck_s_reg[2]) ? ck_s_reg[2] : ck_lvl_reg;
    end
    wire sel    = ~cs_lvl_reg;
    wire rise   = ck_lvl_next & ~ck_lvl_reg & sel;
    wire fall   = ~ck_lvl_next & ck_lvl_reg & sel;
    wire bit_in = di_s_reg[2];

    function automatic logic [7:0] pick_stat(input logic [7:0] op, input logic [7:0] s);
        if (op == `OP_RD_STAT1)      pick_stat = stat1_i;
        else if (op == `OP_RD_STAT2) pick_stat = stat2_i;
        else if (op == `OP_RD_STAT3) pick_stat = stat3_i;
        else if (s[1:0] == 2'h1)     pick_stat = stat5_i;
        else if (s[1:0] == 2'h2)     pick_stat = stat6_i;
        else                         pick_stat = stat4_i;
    endfunction : pick_stat

    flash_frame_pkg::phase_t ph_reg, ph_next;
    logic [7:0]        sh_reg, sh_next, op_reg, op_next, sel_reg, sel_next;
    logic [7:0]        out_reg, out_next;
    logic [2:0]        bit_reg, bit_next;
    logic [1:0]        ab_reg, ab_next;
    logic [ADDR_W-1:0] addr_reg, addr_next, wa_reg, wa_next;
    logic              seq_on_reg, seq_on_next;
    logic              miso_next, oe_next;
    logic              seq_wr_next, buf_next, wren_next, swr_next;
    logic [ADDR_W-1:0] buf_addr_next;
    logic [1:0]        sidx_next;
    logic [7:0]        sdat_next;
    logic [7:0]        byte_in;

    always_comb begin
        ph_next = ph_reg;
        sh_next = sh_reg;
        op_next = op_reg;
        sel_next = sel_reg;
        out_next = out_reg;
        bit_next = bit_reg;
        ab_next = ab_reg;
        addr_next = addr_reg;
        wa_next = wa_reg;
        seq_on_next = seq_on_reg;
        miso_next = miso_o;
        oe_next = miso_oe_o;
        seq_wr_next = 1'b0;
        buf_next = 1'b0;
        wren_next = 1'b0;
        swr_next = 1'b0;
        buf_addr_next = buf_addr_o;
        sidx_next = stat_idx_o;
        sdat_next = stat_data_o;
        byte_in = {sh_reg[6:0], bit_in};
        if (!sel) begin
            // Frame end: a partial frame just drops back to idle
            if (ph_reg == flash_frame_pkg::PH_DONE && op_reg == `OP_BUF_TO_ARRAY) begin
                buf_next = 1'b1;
                buf_addr_next = addr_reg;
            end
            if (ph_reg == flash_frame_pkg::PH_DONE && op_reg == `OP_VOL_WREN)
                wren_next = 1'b1;
            ph_next = flash_frame_pkg::PH_OPCODE;
            bit_next = 3'h0;
            oe_next = 1'b0;
            miso_next = 1'b0;
        end else if (rise) begin
            sh_next = byte_in;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                case (ph_reg)
                    flash_frame_pkg::PH_OPCODE: begin
                        op_next = byte_in;
                        ab_next = 2'h0;
                        if (byte_in == `OP_SEQ_PROG_A || byte_in == `OP_SEQ_PROG_B) begin
                            // Address only on the first frame of a sequence
                            ph_next = seq_on_reg ? flash_frame_pkg::PH_DATA_IN
                                                 : flash_frame_pkg::PH_ADDR;
                        end else if (byte_in == `OP_BUF_TO_ARRAY) begin
                            ph_next = flash_frame_pkg::PH_ADDR;
                        end else if (byte_in == `OP_VOL_WREN) begin
                            ph_next = flash_frame_pkg::PH_DONE;
                        end else if (byte_in == `OP_RD_STAT1 || byte_in == `OP_RD_STAT2
                                     || byte_in == `OP_RD_STAT3) begin
                            out_next = pick_stat(byte_in, 8'h00);
                            ph_next = flash_frame_pkg::PH_DATA_OUT;
                        end else if (byte_in == `OP_RD_STAT_SEL) begin
                            ph_next = flash_frame_pkg::PH_SEL;
                        end else if (byte_in == `OP_WR_STAT1 || byte_in == `OP_WR_STAT2
                                     || byte_in == `OP_WR_STAT3) begin
                            ph_next = flash_frame_pkg::PH_DATA_IN;
                        end else begin
                            ph_next = flash_frame_pkg::PH_IGNORE;
                        end
                    end
                    flash_frame_pkg::PH_ADDR: begin
                        addr_next = {addr_reg[ADDR_W-9:0], byte_in};
                        ab_next = ab_reg + 2'h1;
                        if (ab_reg == `ADDR_BYTES - 2'h1) begin
                            if (op_reg == `OP_BUF_TO_ARRAY) ph_next = flash_frame_pkg::PH_DONE;
                            else begin
                                wa_next = {addr_reg[ADDR_W-9:0], byte_in};
                                ph_next = flash_frame_pkg::PH_DATA_IN;
                            end
                        end
                    end
                    flash_frame_pkg::PH_SEL: begin
                        sel_next = byte_in;
                        ph_next = flash_frame_pkg::PH_DUMMY;
                    end
                    flash_frame_pkg::PH_DUMMY: begin
                        // Value discarded, only the eight clocks matter
                        out_next = pick_stat(op_reg, sel_reg);
                        ph_next = flash_frame_pkg::PH_DATA_OUT;
                    end
                    flash_frame_pkg::PH_DATA_IN: begin
                        ph_next = flash_frame_pkg::PH_DONE;
                        if (op_reg == `OP_SEQ_PROG_A || op_reg == `OP_SEQ_PROG_B) begin
                            seq_wr_next = 1'b1;
                            sdat_next = byte_in;
                            buf_addr_next = buf_addr_o;
                            wa_next = wa_reg + ADDR_W'(1);
                            seq_on_next = 1'b1;
                        end else begin
                            swr_next = 1'b1;
                            sdat_next = byte_in;
                            sidx_next = (op_reg == `OP_WR_STAT1) ? 2'h0 :
                                        (op_reg == `OP_WR_STAT2) ? 2'h1 : 2'h2;
                        end
                    end
                    flash_frame_pkg::PH_DATA_OUT: ph_next = flash_frame_pkg::PH_DONE;
                    default: ph_next = ph_reg;
                endcase
            end
        end else if (fall) begin
            // Shift out on falling edges while returning a status byte
            if (ph_reg == flash_frame_pkg::PH_DATA_OUT) begin
                oe_next = 1'b1;
                miso_next = out_reg[7];
                out_next = {out_reg[6:0], 1'b0};
            end else begin
                oe_next = 1'b0;
            end
        end
        // A release cut into a status read must free the line in the same cycle
        if (cs_lvl_next) begin
            oe_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_lvl_reg <= 1'b1;
            ck_lvl_reg <= 1'b0;
            ph_reg <= flash_frame_pkg::PH_OPCODE;
            sh_reg <= 8'h00;
            op_reg <= 8'h00;
            sel_reg <= 8'h00;
            out_reg <= 8'h00;
            bit_reg <= 3'h0;
            ab_reg <= 2'h0;
            addr_reg <= '0;
            wa_reg <= '0;
            seq_on_reg <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
            seq_wr_o <= 1'b0;
            seq_addr_o <= '0;
            seq_data_o <= 8'h00;
            buf_prog_o <= 1'b0;
            buf_addr_o <= '0;
            vol_wren_o <= 1'b0;
            stat_wr_o <= 1'b0;
            stat_idx_o <= 2'h0;
            stat_data_o <= `STAT_RESET;
        end else begin
            cs_lvl_reg <= cs_lvl_next;
            ck_lvl_reg <= ck_lvl_next;
            ph_reg <= ph_next;
            sh_reg <= sh_next;
            op_reg <= op_next;
            sel_reg <= sel_next;
            out_reg <= out_next;
            bit_reg <= bit_next;
            ab_reg <= ab_next;
            addr_reg <= addr_next;
            wa_reg <= wa_next;
            seq_on_reg <= seq_on_next;
            miso_o <= miso_next;
            miso_oe_o <= oe_next;
            seq_wr_o <= seq_wr_next;
            if (seq_wr_next) begin
                seq_addr_o <= wa_reg;
                seq_data_o <= sdat_next;
            end
            buf_prog_o <= buf_next;
            buf_addr_o <= buf_addr_next;
            vol_wren_o <= wren_next;
            stat_wr_o <= swr_next;
            stat_idx_o <= sidx_next;
            stat_data_o <= swr_next ? sdat_next : stat_data_o;
        end
    end

    // Checks
    sequence s_cs_rise;
        $rose(cs_lvl_reg);
    endsequence
    prop_idle_on_release_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_cs_rise |=> ph_reg == flash_frame_pkg::PH_OPCODE)
        else $error("Frame release did not return to idle");
    bad_op_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ph_reg == flash_frame_pkg::PH_IGNORE |-> !seq_wr_next && !swr_next && !miso_oe_o)
        else $error("Ignored frame produced activity");
    seq_addr_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        seq_wr_o |-> wa_reg == seq_addr_o + ADDR_W'(1))
        else $error("Sequential address did not advance");
    stat_wr_idx_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        stat_wr_o |-> stat_idx_o != 2'h3)
        else $error("Status write with bad index");
    wren_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        vol_wren_o |-> $past(op_reg) == `OP_VOL_WREN)
        else $error("Write enable pulse without opcode");
    buf_prog_op_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        buf_prog_o |-> op_reg == `OP_BUF_TO_ARRAY && cs_lvl_reg)
        else $error("Buffer program without its opcode");
    out_oe_phase_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        miso_oe_o |-> !cs_lvl_reg)
        else $error("Output driven outside a frame");
    seq_first_addr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(seq_on_reg) |-> seq_wr_o)
        else $error("Sequence armed without a write");
endmodule : flash_frame

// file: test/spi_host_model.sv
// Behavioural host controller that drives chip select, serial clock and data in.
// Assumes mode 0 framing and a 64 ns serial clock period.
`timescale 1ns/10ps

module spi_host_model (
    // Clock
    input  wire logic sys_clk_i,
    // Serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // The serial clock stands low outside frames
    task automatic begin_f;
        @(posedge sys_clk_i);
        #1;
        cs_n_o = 1'b0;
        #32;
    endtask : begin_f

    // Undriven return data reads as unknown so a silent device cannot match
    task automatic put(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #32;
            sclk_o = 1'b1;
            rx[i] = (miso_oe_i === 1'b1) ? miso_i : 1'bx;
            #32;
            sclk_o = 1'b0;
        end
    endtask : put

    // Released data line shows the inverse so a stale bit is never reused
    task automatic end_f;
        #32;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (12) @(posedge sys_clk_i);
        #1;
    endtask : end_f
endmodule : spi_host_model

// file: test/tb_spi_flash_command_framing.sv
// Self-checking bench for the flash command framing block.
// Assumes the host model drives the serial pins; strobes are counted here.
`timescale 1ns/10ps
`include "flash_frame_defs.svh"

module tb_spi_flash_command_framing;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cs_n, sclk, mosi, miso, miso_oe;
    logic        seq_wr, buf_prog, vol_wren, stat_wr;
    logic [23:0] seq_addr, buf_addr;
    logic [7:0]  seq_data, stat_data;
    logic [1:0]  stat_idx;
    logic [7:0]  st [0:5] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hc3, 8'h5a};
    int          mismatches = 0;
    int          compares = 0;
    int          n_seq = 0, n_buf = 0, n_wren = 0, n_stat = 0;

    always #2.5 sys_clk = ~sys_clk;

    spi_host_model host (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
                         .miso_i(miso), .miso_oe_i(miso_oe));

    flash_frame DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .seq_wr_o(seq_wr),
        .seq_addr_o(seq_addr), .seq_data_o(seq_data), .buf_prog_o(buf_prog),
        .buf_addr_o(buf_addr), .vol_wren_o(vol_wren), .stat_wr_o(stat_wr),
        .stat_idx_o(stat_idx), .stat_data_o(stat_data), .stat1_i(st[0]), .stat2_i(st[1]),
        .stat3_i(st[2]), .stat4_i(st[3]), .stat5_i(st[4]), .stat6_i(st[5]));

    always @(posedge sys_clk) begin
        n_seq  += (seq_wr === 1'b1);
        n_buf  += (buf_prog === 1'b1);
        n_wren += (vol_wren === 1'b1);
        n_stat += (stat_wr === 1'b1);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Sends n bytes, first byte in the highest used slot; rx is the last byte back
    task automatic frame(input logic [47:0] b, input int n, output logic [7:0] rx);
        host.begin_f();
        for (int k = 0; k < n; k++) host.put(b[8*(n-1-k)+:8], rx);
        host.end_f();
    endtask : frame

    task automatic t_seq;
        logic [7:0] r;
        int s = n_seq;
        frame({`OP_SEQ_PROG_A, 24'h0012ff, 8'ha5}, 5, r);
        check(n_seq - s, 1);
        check(seq_addr, 24'h0012ff);
        check(seq_data, 8'ha5);
        frame({`OP_SEQ_PROG_B, 8'h3c}, 2, r);
        check(n_seq - s, 2);
        check(seq_addr, 24'h001300);
        check(seq_data, 8'h3c);
        $display("test sequential program done");
    endtask : t_seq

    task automatic t_buf;
        logic [7:0] r;
        int s = n_buf;
        frame({`OP_BUF_TO_ARRAY, 24'h04a3c1}, 4, r);
        check(n_buf - s, 1);
        check(buf_addr, 24'h04a3c1);
        frame({`OP_BUF_TO_ARRAY, 16'h0102}, 3, r);
        check(n_buf - s, 1);
        $display("test buffer program and short frame done");
    endtask : t_buf

    task automatic t_wren;
        logic [7:0] r;
        int s = n_wren;
        frame(`OP_VOL_WREN, 1, r);
        check(n_wren - s, 1);
        $display("test volatile write enable done");
    endtask : t_wren

    task automatic t_rd;
        logic [7:0] r;
        logic [7:0] ops [0:2] = '{`OP_RD_STAT1, `OP_RD_STAT2, `OP_RD_STAT3};
        for (int i = 0; i < 3; i++) begin
            frame({ops[i], 8'hff}, 2, r);
            check(r, st[i]);
            frame({`OP_RD_STAT_SEL, 6'h00, i[1:0], 8'ha5 ^ i[7:0], 8'h00}, 4, r);
            check(r, st[3+i]);
        end
        $display("test status reads done");
    endtask : t_rd

    task automatic t_wr;
        logic [7:0] r;
        logic [7:0] ops [0:2] = '{`OP_WR_STAT1, `OP_WR_STAT2, `OP_WR_STAT3};
        int s = n_stat;
        for (int i = 0; i < 3; i++) begin
            frame({ops[i], 8'h96 ^ i[7:0]}, 2, r);
            check(n_stat - s, i + 1);
            check(stat_idx, i[1:0]);
            check(stat_data, 8'h96 ^ i[7:0]);
        end
        $display("test status writes done");
    endtask : t_wr

    // A bad opcode followed by valid-looking bytes must strobe nothing
    task automatic t_bad;
        logic [7:0] r;
        int s = n_seq + n_buf + n_wren + n_stat;
        frame({8'h9f, `OP_WR_STAT1, 8'h77, `OP_VOL_WREN}, 4, r);
        check(n_seq + n_buf + n_wren + n_stat - s, 0);
        frame(`OP_VOL_WREN, 1, r);
        check(n_seq + n_buf + n_wren + n_stat - s, 1);
        $display("test unsupported opcode done");
    endtask : t_bad

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Whole sequence needs about 25 us; the limit leaves wide margin
    initial begin
        #300000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        t_seq();
        t_buf();
        t_wren();
        t_rd();
        t_wr();
        t_bad();
        complete_run();
    end
endmodule : tb_spi_flash_command_framing
